//--- hdl/rtc_pkg.sv
// Constants, types and register layout of the clock control and status registers.
// Assumes a 40 MHz system clock from which the 32.768 kHz time base is derived.
package rtc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RTC_CLK_HZ = 40_000_000;
    localparam int RTC_CLK_PERIOD_NS = 25;
    localparam int RTC_OSC_HZ = 32_768;
    localparam int RTC_OSC_DIV = (RTC_CLK_HZ + RTC_OSC_HZ / 2) / RTC_OSC_HZ;
    localparam int RTC_LEAD_NS = 244_000;
    localparam int RTC_BUSY_NS = 1_948_000;
    localparam int RTC_LEAD_CYC = (RTC_LEAD_NS + RTC_CLK_PERIOD_NS - 1) / RTC_CLK_PERIOD_NS;
    localparam int RTC_BUSY_CYC = (RTC_BUSY_NS + RTC_CLK_PERIOD_NS - 1) / RTC_CLK_PERIOD_NS;
    localparam logic [14:0] RTC_HALF_SEC = 15'h4000;
    localparam logic [14:0] RTC_LEAD_TICKS = 15'h0008;
    localparam logic [14:0] RTC_LEAD_POINT = RTC_HALF_SEC - RTC_LEAD_TICKS;
    localparam int RTC_DIV_W = 22;
    localparam int RTC_PRESC_W = 11;
    localparam int RTC_TMR_W = 17;

    // ------------------------------------------------------------
    // Register indices; the byte address is the index shifted left by two
    // ------------------------------------------------------------
    localparam logic [5:0] RTC_IDX_RATE_DIVIDER_CTRL = 6'h0A;
    localparam logic [5:0] RTC_IDX_IRQ_FORMAT_CTRL = 6'h0B;
    localparam logic [5:0] RTC_IDX_IRQ_FLAGS = 6'h0C;

    // Field positions
    localparam int RTC_A_PEND = 7;
    localparam int RTC_B_SET = 7;
    localparam int RTC_B_PEN = 6;
    localparam int RTC_B_AEN = 5;
    localparam int RTC_B_UEN = 4;
    localparam int RTC_B_BIN = 2;
    localparam int RTC_B_H24 = 1;
    localparam int RTC_C_SUM = 7;
    localparam int RTC_C_PFL = 6;
    localparam int RTC_C_AFL = 5;
    localparam int RTC_C_UFL = 4;

    // Divider modes, alarm don't-care code, rate select codes and taps
    localparam logic [2:0] RTC_DV_OFF0 = 3'h0;
    localparam logic [2:0] RTC_DV_OFF1 = 3'h1;
    localparam logic [1:0] RTC_DV_RST_HI = 2'h3;
    localparam logic [1:0] RTC_ALARM_ANY = 2'h3;
    localparam logic [3:0] RTC_RS_NONE = 4'h0;
    localparam logic [3:0] RTC_RS_ALIAS1 = 4'h1;
    localparam logic [3:0] RTC_RS_ALIAS2 = 4'h2;
    localparam logic [4:0] RTC_TAP_ALIAS1 = 5'h06;
    localparam logic [4:0] RTC_TAP_ALIAS2 = 5'h07;
    localparam logic [4:0] RTC_TAP_OFFSET = 5'h02;

    // Reset values and bus response codes
    localparam logic [2:0] RTC_DV_RESET = 3'h2;
    localparam logic [3:0] RTC_RS_RESET = 4'h0;
    localparam logic [1:0] RTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RTC_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RTC_UPD_IDLE = 2'b00,
        RTC_UPD_LEAD = 2'b01,
        RTC_UPD_BUSY = 2'b10
    } rtc_upd_state_t;

    typedef enum logic [1:0] {
        RTC_SEL_NONE = 2'b00,
        RTC_SEL_A = 2'b01,
        RTC_SEL_B = 2'b10,
        RTC_SEL_C = 2'b11
    } rtc_sel_t;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtc_hms_t;

    typedef struct packed {
        logic [RTC_PRESC_W-1:0] presc;
        logic [RTC_DIV_W-1:0] div;
        rtc_upd_state_t upd;
        logic [RTC_TMR_W-1:0] tmr;
        logic [2:0] dv;
        logic [3:0] rs;
        logic set;
        logic pen;
        logic aen;
        logic uen;
        logic bin;
        logic h24;
        logic pfl;
        logic afl;
        logic ufl;
        logic adv;
        logic aw_hold;
        logic [7:0] awaddr;
        logic w_hold;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } rtc_state_t;

endpackage

//--- hdl/rtc_ctrl_status.sv
// Control and status registers of the real-time clock, with divider chain,
// periodic rate taps, update-cycle sequencing, event flags and interrupt output.
// Assumes the calendar counters and alarm bytes live outside and are presented
// on time_now and alarm_time; they advance on time_advance.
//
// Notes on behaviour
// R01: Registers reachable at all times, even mid-update.
// R02: Pending flag leads update by 244us; read-only.
// R03: Setting inhibit blocks updates, then clears pending flag.
// R04: Mode bits run, stop, test or reset divider.
// R05: First update half second after divider reset ends.
// R06: Mode bits read/write, kept over main reset.
// R07: Rate select picks one of thirteen taps.
// R08: Rate bits read/write, kept over main reset.
// R09: Inhibit clear advances once per second; set aborts.
// R10: Periodic enable gates flag; main reset clears it.
// R11: Alarm when hours, minutes, seconds match or don't-care.
// R12: Alarm enable gates flag; main reset clears it.
// R13: Update enable cleared by main reset or inhibit rising.
// R14: Reserved and daylight-saving bits read zero.
// R15: Format bit selects binary or BCD; software only.
// R16: Hour bit selects 24 or 12 hours.
// R17: Summary bit set while enabled flag pending; output low.
// R18: Flags cleared by flag-register read or main reset.
// R19: Periodic flag sets on tap edge regardless of enable.
// R20: Alarm flag sets on time match.
// R21: Update-done flag sets at end of update.
// R22: Low four flag bits read zero, ignore writes.
// R23: Events during flag read are kept, not lost.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rtc_ctrl_status
    import rtc_pkg::*;
#(
    parameter int LEAD_CYC = RTC_LEAD_CYC,
    parameter int BUSY_CYC = RTC_BUSY_CYC
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic main_power_on_reset,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Calendar side
    input wire rtc_hms_t time_now,
    input wire rtc_hms_t alarm_time,
    output logic time_advance,
    output logic binary_format_select,
    output logic hour_24_select,
    // Interrupt
    output logic interrupt_out_n
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic rtc_sel_t reg_sel(input logic [7:0] addr);
        rtc_sel_t sel;
        if (addr[7:2] == RTC_IDX_RATE_DIVIDER_CTRL)
            sel = RTC_SEL_A;
        else if (addr[7:2] == RTC_IDX_IRQ_FORMAT_CTRL)
            sel = RTC_SEL_B;
        else if (addr[7:2] == RTC_IDX_IRQ_FLAGS)
            sel = RTC_SEL_C;
        else
            sel = RTC_SEL_NONE;
        return sel;
    endfunction

    // Divider bit whose falling edge marks one periodic interval
    function automatic logic [4:0] tap_of(input logic [3:0] rs);
        logic [4:0] tap;
        if (rs == RTC_RS_ALIAS1)
            tap = RTC_TAP_ALIAS1;
        else if (rs == RTC_RS_ALIAS2)
            tap = RTC_TAP_ALIAS2;
        else
            tap = {1'b0, rs} - RTC_TAP_OFFSET;
        return tap;
    endfunction

    function automatic logic byte_match(input logic [7:0] t, input logic [7:0] a);
        return (a[7:6] == RTC_ALARM_ANY) || (a == t);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rtc_state_t s_q;
    rtc_state_t s_d;
    logic [7:0] reg_a;
    logic [7:0] reg_b;
    logic [7:0] reg_c;
    logic summary;

    always_comb
    begin
        summary = (s_q.pfl && s_q.pen) || (s_q.afl && s_q.aen) || (s_q.ufl && s_q.uen); // see R17
        reg_a = {(s_q.upd != RTC_UPD_IDLE), s_q.dv, s_q.rs}; // see R02
        reg_b = 8'h00; // see R14
        reg_b[RTC_B_SET] = s_q.set;
        reg_b[RTC_B_PEN] = s_q.pen;
        reg_b[RTC_B_AEN] = s_q.aen;
        reg_b[RTC_B_UEN] = s_q.uen;
        reg_b[RTC_B_BIN] = s_q.bin;
        reg_b[RTC_B_H24] = s_q.h24;
        reg_c = 8'h00; // see R22
        reg_c[RTC_C_SUM] = summary;
        reg_c[RTC_C_PFL] = s_q.pfl;
        reg_c[RTC_C_AFL] = s_q.afl;
        reg_c[RTC_C_UFL] = s_q.ufl;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic tick;
    logic running;
    logic [RTC_DIV_W-1:0] div_n;
    logic [4:0] tap;
    logic per_evt;
    logic alm_evt;
    logic end_evt;
    logic lead_evt;
    logic rd_go;
    logic rd_clear;
    logic wr_go;
    rtc_sel_t wsel;
    rtc_sel_t rsel;

    always_comb
    begin
        s_d = s_q;
        s_d.adv = 1'b0;
        per_evt = 1'b0;
        alm_evt = 1'b0;
        end_evt = 1'b0;
        rd_clear = 1'b0;

        // Time base: one enable per 32.768 kHz period
        tick = (s_q.presc == RTC_PRESC_W'(RTC_OSC_DIV - 1));
        s_d.presc = tick ? '0 : s_q.presc + 1'b1;

        // Divider chain
        running = (s_q.dv != RTC_DV_OFF0) && (s_q.dv != RTC_DV_OFF1)
            && (s_q.dv[2:1] != RTC_DV_RST_HI); // see R04
        div_n = s_q.div;
        if (s_q.dv[2:1] == RTC_DV_RST_HI)
            div_n = '0; // see R04
        else if (running && tick)
            div_n = s_q.div + 1'b1;
        s_d.div = div_n;

        // Periodic taps: code 3 is the fastest, each step halves the rate
        tap = tap_of(s_q.rs);
        if (s_q.rs != RTC_RS_NONE && s_q.div[tap] && !div_n[tap])
            per_evt = 1'b1; // see R07, R19

        // Lead point sits a fixed lead before each rise of divider bit 14, once per second; from a
        // cleared divider the first update therefore lands half a second on
        lead_evt = running && tick && (div_n[14:0] == RTC_LEAD_POINT); // see R05, R09

        // Update sequencer
        case (s_q.upd)
            RTC_UPD_IDLE:
            begin
                if (lead_evt && !s_q.set)
                begin
                    s_d.upd = RTC_UPD_LEAD;
                    s_d.tmr = '0;
                end
            end
            RTC_UPD_LEAD:
            begin
                s_d.tmr = s_q.tmr + 1'b1;
                if (s_q.tmr == RTC_TMR_W'(LEAD_CYC - 1))
                begin
                    s_d.upd = RTC_UPD_BUSY; // see R02
                    s_d.tmr = '0;
                end
            end
            RTC_UPD_BUSY:
            begin
                s_d.tmr = s_q.tmr + 1'b1;
                if (s_q.tmr == RTC_TMR_W'(BUSY_CYC - 1))
                begin
                    s_d.upd = RTC_UPD_IDLE;
                    s_d.adv = 1'b1; // see R09
                    end_evt = 1'b1; // see R21
                    alm_evt = byte_match(time_now.hour, alarm_time.hour)
                        && byte_match(time_now.min, alarm_time.min)
                        && byte_match(time_now.sec, alarm_time.sec); // see R11, R20
                end
            end
            default:
            begin
                s_d.upd = RTC_UPD_IDLE;
            end
        endcase
        // Inhibit or divider reset aborts any cycle and drops the pending flag
        if (s_q.set || s_q.dv[2:1] == RTC_DV_RST_HI)
        begin
            s_d.upd = RTC_UPD_IDLE; // see R03, R09
            s_d.tmr = '0;
            s_d.adv = 1'b0;
            end_evt = 1'b0;
            alm_evt = 1'b0;
        end

        // AXI4-Lite write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_hold = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_hold = 1'b1;
            s_d.wdata = s_axi_wdata[7:0];
            s_d.wstrb0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;

        wr_go = s_q.aw_hold && s_q.w_hold;
        wsel = reg_sel(s_q.awaddr);
        if (wr_go)
        begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = (wsel == RTC_SEL_NONE) ? RTC_RESP_SLVERR : RTC_RESP_OKAY;
            if (s_q.wstrb0 && wsel == RTC_SEL_A)
            begin
                s_d.dv = s_q.wdata[6:4]; // see R01, R06
                s_d.rs = s_q.wdata[3:0]; // see R08
            end
            else if (s_q.wstrb0 && wsel == RTC_SEL_B)
            begin
                s_d.set = s_q.wdata[RTC_B_SET];
                s_d.pen = s_q.wdata[RTC_B_PEN];
                s_d.aen = s_q.wdata[RTC_B_AEN];
                s_d.uen = s_q.wdata[RTC_B_UEN];
                s_d.bin = s_q.wdata[RTC_B_BIN]; // see R15
                s_d.h24 = s_q.wdata[RTC_B_H24]; // see R16
                if (s_q.wdata[RTC_B_SET] && !s_q.set)
                    s_d.uen = 1'b0; // see R13
            end
        end

        // AXI4-Lite read channel
        rd_go = s_axi_arvalid && s_axi_arready;
        rsel = reg_sel(s_axi_araddr);
        if (s_axi_rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        if (rd_go)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RTC_RESP_OKAY;
            if (rsel == RTC_SEL_A)
                s_d.rdata = reg_a;
            else if (rsel == RTC_SEL_B)
                s_d.rdata = reg_b;
            else if (rsel == RTC_SEL_C)
            begin
                s_d.rdata = reg_c;
                rd_clear = 1'b1; // see R18
            end
            else
            begin
                s_d.rdata = 8'h00;
                s_d.rresp = RTC_RESP_SLVERR;
            end
        end

        // Flags: the read snapshot is taken before the clear, and an event in
        // the clearing cycle survives it
        s_d.pfl = (s_q.pfl && !rd_clear) || per_evt; // see R19, R23
        s_d.afl = (s_q.afl && !rd_clear) || alm_evt; // see R20, R23
        s_d.ufl = (s_q.ufl && !rd_clear) || end_evt; // see R21, R23

        // Main power-on reset: enables and flags only
        if (main_power_on_reset)
        begin
            s_d.pen = 1'b0; // see R10
            s_d.aen = 1'b0; // see R12
            s_d.uen = 1'b0; // see R13
            s_d.pfl = 1'b0; // see R18
            s_d.afl = 1'b0;
            s_d.ufl = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
            s_q.dv <= RTC_DV_RESET;
            s_q.rs <= RTC_RS_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !s_q.aw_hold && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_hold && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = {24'h000000, s_q.rdata};
    assign time_advance = s_q.adv;
    assign binary_format_select = s_q.bin; // see R15
    assign hour_24_select = s_q.h24; // see R16
    assign interrupt_out_n = !summary; // see R10, R12, R17

endmodule

`default_nettype wire

//--- test/rtc_ctrl_status_chk.sv
// Concurrent checks on the ports of the clock control and status block.
// Assumes one clock domain, mclk, with rst_b as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module rtc_ctrl_status_chk
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic main_power_on_reset,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Calendar side and interrupt
    input wire logic time_advance,
    input wire logic binary_format_select,
    input wire logic hour_24_select,
    input wire logic interrupt_out_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Remembers that the read under way targets the flag register
    logic flag_rd_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            flag_rd_q <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            flag_rd_q <= (s_axi_araddr == 8'h30);
    end

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_wr_answer:
    assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_rd_answer:
    assert property (s_rd_take |=> s_axi_rvalid) else $error("read answer late");
    a_wr_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rd_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_bus_refuse:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_rd_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
    a_summary_pin:
    assert property ($rose(s_axi_rvalid) && flag_rd_q |-> s_axi_rdata[7] == !$past(interrupt_out_n))
        else $error("summary bit and pin differ");
    a_por_irq:
    assert property (main_power_on_reset |=> interrupt_out_n) else $error("pin low after reset");
    a_fmt_sw_only:
    assert property ($changed(binary_format_select) || $changed(hour_24_select) |-> $rose(s_axi_bvalid))
        else $error("format changed without write");
    a_adv_pulse:
    assert property (time_advance |=> !time_advance) else $error("advance pulse too long");
endmodule

bind rtc_ctrl_status rtc_ctrl_status_chk rtc_ctrl_status_chk_inst (
    .mclk(mclk), .rst_b(rst_b), .main_power_on_reset(main_power_on_reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .time_advance(time_advance), .binary_format_select(binary_format_select),
    .hour_24_select(hour_24_select), .interrupt_out_n(interrupt_out_n));

`default_nettype wire

//--- test/rtc_ctrl_status_test.sv
// Self-checking bench of the clock control and status registers.
// Drives the register bus as an AXI4-Lite master; calendar inputs held fixed.
`timescale 1ns/1ps
`default_nettype none

module rtc_ctrl_status_test
    import rtc_pkg::*;
;
    localparam logic [7:0] A_AD = {RTC_IDX_RATE_DIVIDER_CTRL, 2'b00};
    localparam logic [7:0] B_AD = {RTC_IDX_IRQ_FORMAT_CTRL, 2'b00};
    localparam logic [7:0] C_AD = {RTC_IDX_IRQ_FLAGS, 2'b00};
    localparam int LIMIT = 90000;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic main_power_on_reset = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic time_advance, binary_format_select, hour_24_select, interrupt_out_n;
    rtc_hms_t time_now = 24'h000000;
    rtc_hms_t alarm_time = 24'h010203;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    rtc_ctrl_status #(.LEAD_CYC(4), .BUSY_CYC(8)) rtc_ctrl_status_inst (
        .mclk(mclk), .rst_b(rst_b), .main_power_on_reset(main_power_on_reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .time_now(time_now),
        .alarm_time(alarm_time), .time_advance(time_advance),
        .binary_format_select(binary_format_select), .hour_24_select(hour_24_select),
        .interrupt_out_n(interrupt_out_n));

    always #12.5 mclk = ~mclk;

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge mclk);
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        @(posedge mclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge mclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er,
                          input string name);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(name, {24'h0, e}, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic pin_chk(input logic e);
        chk("interrupt_out_n", {31'h0, e}, {31'h0, interrupt_out_n});
    endtask

    task automatic por_pulse();
        @(posedge mclk);
        main_power_on_reset <= 1'b1;
        @(posedge mclk);
        main_power_on_reset <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(A_AD, 8'h20, RTC_RESP_OKAY, "reg_a");
        rd_chk(B_AD, 8'h00, RTC_RESP_OKAY, "reg_b");
        rd_chk(C_AD, 8'h00, RTC_RESP_OKAY, "reg_c");
        pin_chk(1'b1);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr_chk(A_AD, 8'hFF, RTC_RESP_OKAY);
        rd_chk(A_AD, 8'h7F, RTC_RESP_OKAY, "reg_a");
        wr_chk(A_AD, 8'h23, RTC_RESP_OKAY);
        wr_chk(B_AD, 8'hFF, RTC_RESP_OKAY);
        rd_chk(B_AD, 8'hE6, RTC_RESP_OKAY, "reg_b");
        chk("format", 32'h3, {30'h0, binary_format_select, hour_24_select});
        wr_chk(B_AD, 8'h96, RTC_RESP_OKAY);
        rd_chk(B_AD, 8'h96, RTC_RESP_OKAY, "reg_b");
        por_pulse();
        rd_chk(B_AD, 8'h86, RTC_RESP_OKAY, "reg_b");
        rd_chk(A_AD, 8'h23, RTC_RESP_OKAY, "reg_a");
        wr_chk(B_AD, 8'h00, RTC_RESP_OKAY);
        chk("format", 32'h0, {30'h0, binary_format_select, hour_24_select});
        $display("test registers done");
    endtask

    task automatic t_bus();
        rd_chk(8'h34, 8'h00, RTC_RESP_SLVERR, "unmapped");
        wr_chk(8'h00, 8'h55, RTC_RESP_SLVERR);
        wr_chk(C_AD, 8'hFF, RTC_RESP_OKAY);
        rd_chk(C_AD, 8'h00, RTC_RESP_OKAY, "reg_c");
        $display("test bus done");
    endtask

    task automatic t_periodic();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr_chk(B_AD, 8'h40, RTC_RESP_OKAY);
        rd(C_AD, d, r);
        n = 0;
        while (interrupt_out_n !== 1'b0 && n < 6000)
        begin
            @(posedge mclk);
            n++;
        end
        pin_chk(1'b0);
        rd_chk(C_AD, 8'hC0, RTC_RESP_OKAY, "reg_c");
        pin_chk(1'b1);
        rd_chk(C_AD, 8'h00, RTC_RESP_OKAY, "reg_c");
        wr_chk(B_AD, 8'h00, RTC_RESP_OKAY);
        rd(C_AD, d, r);
        repeat (5000) @(posedge mclk);
        pin_chk(1'b1);
        wr_chk(B_AD, 8'h40, RTC_RESP_OKAY);
        pin_chk(1'b0);
        por_pulse();
        pin_chk(1'b1);
        rd_chk(C_AD, 8'h00, RTC_RESP_OKAY, "reg_c");
        $display("test periodic done");
    endtask

    task automatic t_modes();
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:0];
            wr_chk(A_AD, {1'b0, m, 4'h3}, RTC_RESP_OKAY);
            rd(C_AD, d, r);
            repeat (5000) @(posedge mclk);
            rd_chk(C_AD, (m >= 3'h2 && m <= 3'h5) ? 8'h40 : 8'h00, RTC_RESP_OKAY, "mode");
        end
        $display("test divider modes done");
    endtask

    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_regs();
        t_bus();
        t_periodic();
        t_modes();
        summarize();
    end
endmodule

`default_nettype wire
